// >>> src/sphg_pkg.sv
// Shared constants and types of the slave host port with flag and gate logic.
package sphg_pkg;

    // ******************************************************************
    // Firmware instruction opcodes and host gate command values
    // ******************************************************************
    localparam logic [7:0] SPHG_OP_STATUS_MOVE = 8'h90;
    localparam logic [7:0] SPHG_OP_DMA_EN = 8'he5;
    localparam logic [7:0] SPHG_OP_GATE_EN = 8'h33;
    localparam logic [7:0] SPHG_OP_FLAGS_EN = 8'hf5;
    localparam logic [7:0] SPHG_CMD_GATE = 8'hd1;
    localparam logic [7:0] SPHG_CMD_GATE_END = 8'hff;

    // ******************************************************************
    // Firmware register offsets
    // ******************************************************************
    localparam logic [2:0] SPHG_REG_DATA = 3'h0;
    localparam logic [2:0] SPHG_REG_STATUS = 3'h1;
    localparam logic [2:0] SPHG_REG_INSTR = 3'h2;
    localparam logic [2:0] SPHG_REG_PORT = 3'h3;
    localparam logic [2:0] SPHG_REG_MODE = 3'h4;

    // ******************************************************************
    // Field positions and reset values
    // ******************************************************************
    localparam int SPHG_ST_OBF = 0;
    localparam int SPHG_ST_IBF = 1;
    localparam int SPHG_ST_F1 = 3;
    localparam int SPHG_ST_USER = 4;
    localparam int SPHG_P_GATE = 1;
    localparam int SPHG_P_OFLAG = 4;
    localparam int SPHG_P_IFLAG = 5;
    localparam int SPHG_P_REQ = 6;
    localparam int SPHG_P_ACK = 7;
    localparam int SPHG_GATE_DB = 1;
    localparam int SPHG_FW_DW = 16;
    localparam logic [7:0] SPHG_STATUS_RST = 8'h00;
    localparam logic [7:0] SPHG_PORT_RST = 8'hff;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [1:0] {
        SPHG_GATE_IDLE,
        SPHG_GATE_ARMED,
        SPHG_GATE_DONE
    } sphg_gate_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic register_select;
        logic [7:0] din;
    } sphg_host_in_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [SPHG_FW_DW-1:0] wdata;
        logic wr;
        logic rd;
    } sphg_fw_req_t;

    typedef struct packed {
        logic prev;
    } sphg_edge_t;

    typedef struct packed {
        logic [7:0] in_buf;
        logic [7:0] out_buf;
        logic [7:0] host_status;
        logic [7:0] port_latch;
        logic [7:0] pins;
        logic [7:0] host_dout;
        logic [SPHG_FW_DW-1:0] fw_rdata;
        logic flags_en;
        logic dma_en;
        logic gate_en;
        logic gate_pin;
        sphg_gate_t gate;
        logic wr_rs;
        logic rd_rs;
        logic [7:0] wr_data;
        logic user_pend;
        logic [3:0] user_val;
    } sphg_state_t;

endpackage

// >>> src/sphg_strobe_edge.sv
// Trailing-edge detector for one host strobe.
`timescale 1ns/1ns
module sphg_strobe_edge
    import sphg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Strobe level and its trailing edge
    input wire logic level,
    output logic trail
);

    sphg_edge_t s;
    sphg_edge_t next_s;

    always_comb begin
        next_s = s;
        next_s.prev = level;
    end

    // The pulse comes in the same cycle that the strobe is first seen gone.
    assign trail = s.prev & ~level;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// >>> src/sphg_host_port.sv
// Host slave port with user status bits, buffer flags, transfer handshake
// and address-line gate logic.
//
// Operation
// - Separate input buffer for host writes, output buffer for host reads.
// - Status move copies accumulator bits 7..4 into status bits 7..4 only.
// - Strobes are edge sensitive; flags change after the trailing edge.
// - Firmware status update waits while the host is reading status.
// - Port bits 4 and 5 are plain pins until the flag-enable instruction.
// - With flags on, bit 4 one follows output full; zero holds low.
// - With flags on, bit 5 one shows inverted input full; zero holds low.
// - After transfer-enable, port bit 6 written one raises the request.
// - Request drops on acknowledge with a strobe, or transfer-enable again; a firmware port write with bit 6 zero also drops it.
// - With transfers on, port bit 7 is the acknowledge and buffer select.
// - Gate logic turns on by instruction and stays on until reset.
// - Once gated, port bit 1 is readable but only host sequences alter it.
// - A valid gate sequence copies data bit 1 onto port bit 1.
// - Valid gate sequence bytes never set input full nor reach firmware.
// - End command after a gate command or a valid sequence is silent; else sets input full.
// - Data bus drives only on select and read; writes need select, write.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module sphg_host_port
    import sphg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Host parallel port
    input wire sphg_host_in_t host_in,
    output logic [7:0] host_dout,
    output logic host_dout_oe_n,
    // Acknowledge pin from the transfer controller, active low
    input wire logic acknowledge_pin_n,
    // Port two pin levels
    output logic [7:0] port_pins,
    // Firmware register port
    input wire sphg_fw_req_t fw_req,
    output logic [SPHG_FW_DW-1:0] fw_rdata
);

    // ******************************************************************
    // State
    // ******************************************************************
    sphg_state_t s;
    sphg_state_t next_s;

    logic transfer_acknowledge;
    logic sel;
    logic rd_act;
    logic wr_act;
    logic rd_trail;
    logic wr_trail;
    logic status_lock;

    // ******************************************************************
    // Helpers
    // ******************************************************************
    function automatic logic [7:0] pin_levels(input sphg_state_t st);
        logic [7:0] p;
        p = st.port_latch;
        if (st.gate_en) begin
            p[SPHG_P_GATE] = st.gate_pin;
        end
        if (st.flags_en) begin
            p[SPHG_P_OFLAG] = st.port_latch[SPHG_P_OFLAG]
                & st.host_status[SPHG_ST_OBF];
        end
        if (st.flags_en) begin
            p[SPHG_P_IFLAG] = st.port_latch[SPHG_P_IFLAG]
                & ~st.host_status[SPHG_ST_IBF];
        end
        return p;
    endfunction

    // ******************************************************************
    // Host strobe qualification
    // ******************************************************************
    // acknowledge selects buffers
    assign transfer_acknowledge = s.dma_en & ~acknowledge_pin_n;
    assign sel = ~host_in.cs_n | transfer_acknowledge;
    assign rd_act = sel & ~host_in.rd_n;
    assign wr_act = sel & ~host_in.wr_n;
    assign status_lock = rd_act & host_in.register_select & ~transfer_acknowledge;

    sphg_strobe_edge u_rd_edge (
        .mclk(mclk),
        .rst(rst),
        .level(rd_act),
        .trail(rd_trail)
    );

    sphg_strobe_edge u_wr_edge (
        .mclk(mclk),
        .rst(rst),
        .level(wr_act),
        .trail(wr_trail)
    );

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb begin
        logic take_byte;
        take_byte = 1'b0;
        next_s = s;

        // Capture select and data while the strobe is held; the last
        // sample before the trailing edge is the one that counts.
        if (wr_act) begin
            next_s.wr_data = host_in.din;
            next_s.wr_rs = host_in.register_select & ~transfer_acknowledge;
        end
        if (rd_act) begin
            next_s.rd_rs = host_in.register_select & ~transfer_acknowledge;
        end

        // Firmware reads; clears come first so that sets below win.
        if (fw_req.rd) begin
            case (fw_req.addr)
                SPHG_REG_DATA: begin
                    next_s.fw_rdata = {8'h00, s.in_buf};
                    next_s.host_status[SPHG_ST_IBF] = 1'b0;
                end
                SPHG_REG_STATUS: begin
                    next_s.fw_rdata = {8'h00, s.host_status};
                end
                SPHG_REG_PORT: begin
                    next_s.fw_rdata = {8'h00, s.pins};
                    // acknowledge pin is read as input
                    if (s.dma_en) begin
                        next_s.fw_rdata[SPHG_P_ACK] = acknowledge_pin_n;
                    end
                end
                SPHG_REG_MODE: begin
                    next_s.fw_rdata = {10'h000, s.gate, s.user_pend,
                        s.gate_en, s.dma_en, s.flags_en};
                end
                default: begin
                    next_s.fw_rdata = '0;
                end
            endcase
        end

        // output full drops after a data read ends
        if (rd_trail && !s.rd_rs) begin
            next_s.host_status[SPHG_ST_OBF] = 1'b0;
        end

        // acknowledge with a strobe withdraws the request
        if (transfer_acknowledge && (rd_act || wr_act)) begin
            next_s.port_latch[SPHG_P_REQ] = 1'b0;
        end

        // Firmware writes.
        if (fw_req.wr) begin
            case (fw_req.addr)
                SPHG_REG_DATA: begin
                    next_s.out_buf = fw_req.wdata[7:0];
                    next_s.host_status[SPHG_ST_OBF] = 1'b1;
                end
                SPHG_REG_INSTR: begin
                    case (fw_req.wdata[7:0])
                        SPHG_OP_STATUS_MOVE: begin
                            next_s.user_val = fw_req.wdata[15:12];
                            next_s.user_pend = 1'b1;
                        end
                        SPHG_OP_FLAGS_EN: begin
                            next_s.flags_en = 1'b1;
                        end
                        SPHG_OP_DMA_EN: begin
                            next_s.dma_en = 1'b1;
                            next_s.port_latch[SPHG_P_REQ] = 1'b0;
                        end
                        SPHG_OP_GATE_EN: begin
                            next_s.gate_en = 1'b1;
                            next_s.gate_pin = s.pins[SPHG_P_GATE];
                        end
                        default: begin
                            next_s.user_pend = next_s.user_pend;
                        end
                    endcase
                end
                SPHG_REG_PORT: begin
                    next_s.port_latch = fw_req.wdata[7:0];
                    // firmware cannot move the gate pin
                    if (s.gate_en) begin
                        next_s.port_latch[SPHG_P_GATE] =
                            s.port_latch[SPHG_P_GATE];
                    end
                    // request is set by writing one
                    if (!s.dma_en) begin
                        next_s.port_latch[SPHG_P_REQ] =
                            fw_req.wdata[SPHG_P_REQ];
                    end else if (fw_req.wdata[SPHG_P_REQ]) begin
                        next_s.port_latch[SPHG_P_REQ] = 1'b1;
                    end else begin
                        next_s.port_latch[SPHG_P_REQ] =
                            next_s.port_latch[SPHG_P_REQ] & ~s.dma_en;
                    end
                end
                default: begin
                    next_s.fw_rdata = next_s.fw_rdata;
                end
            endcase
        end

        // user bits wait out a host status read
        if (next_s.user_pend && !status_lock) begin
            next_s.host_status[7:SPHG_ST_USER] = next_s.user_val;
            next_s.user_pend = 1'b0;
        end

        // Host write completion and the gate sequencer.
        if (wr_trail) begin
            take_byte = 1'b1;
            if (s.gate_en && s.wr_rs) begin
                if (s.wr_data == SPHG_CMD_GATE) begin
                    next_s.gate = SPHG_GATE_ARMED;
                    take_byte = 1'b0;
                end else if (s.wr_data == SPHG_CMD_GATE_END
                    && s.gate != SPHG_GATE_IDLE) begin
                    next_s.gate = SPHG_GATE_IDLE;
                    take_byte = 1'b0;
                end else begin
                    // any other command breaks the sequence
                    next_s.gate = SPHG_GATE_IDLE;
                end
            end else if (s.gate_en && s.gate == SPHG_GATE_ARMED) begin
                // only data bit one is passed to the pin
                next_s.gate_pin = s.wr_data[SPHG_GATE_DB];
                next_s.gate = SPHG_GATE_DONE;
                take_byte = 1'b0;
            end else begin
                next_s.gate = SPHG_GATE_IDLE;
            end
        end

        if (take_byte) begin
            next_s.in_buf = s.wr_data;
            next_s.host_status[SPHG_ST_IBF] = 1'b1;
            next_s.host_status[SPHG_ST_F1] = s.wr_rs;
        end

        // Pins and read data come straight from flops.
        next_s.pins = pin_levels(next_s);
        if (host_in.register_select && !transfer_acknowledge) begin
            next_s.host_dout = s.host_status;
        end else begin
            next_s.host_dout = s.out_buf;
        end
    end

    // ******************************************************************
    // Registers
    // ******************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '{
                in_buf: 8'h00,
                out_buf: 8'h00,
                host_status: SPHG_STATUS_RST,
                port_latch: SPHG_PORT_RST,
                pins: SPHG_PORT_RST,
                host_dout: 8'h00,
                fw_rdata: 16'h0000,
                flags_en: 1'b0,
                dma_en: 1'b0,
                gate_en: 1'b0,
                gate_pin: 1'b0,
                gate: SPHG_GATE_IDLE,
                wr_rs: 1'b0,
                rd_rs: 1'b0,
                wr_data: 8'h00,
                user_pend: 1'b0,
                user_val: 4'h0
            };
        end else begin
            s <= next_s;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    // The enable is combinational so the bus is released the moment the
    // strobe goes away; a registered enable would overlap the next master.
    // drive only on select and read
    assign host_dout_oe_n = ~rd_act;
    assign host_dout = s.host_dout;
    assign port_pins = s.pins;
    assign fw_rdata = s.fw_rdata;

endmodule

// >>> test/sphg_host_port_sva.sv
// Concurrent checks on the ports of the slave host port.
`timescale 1ns/1ns
module sphg_host_port_sva
    import sphg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Watched ports
    input wire sphg_host_in_t host_in,
    input wire logic [7:0] host_dout,
    input wire logic host_dout_oe_n,
    input wire logic acknowledge_pin_n,
    input wire logic [7:0] port_pins,
    input wire sphg_fw_req_t fw_req,
    input wire logic [SPHG_FW_DW-1:0] fw_rdata
);
    // ******************************************************************
    // Strobe history and assertions
    // ******************************************************************
    logic wr_prev;
    logic rd_prev;
    logic [3:0] wr_hist;
    logic [3:0] act_hist;
    logic trail_w;
    logic act;
    logic st_rd;
    assign trail_w = host_in.wr_n && !wr_prev;
    assign act = fw_req.wr || fw_req.rd || !host_in.wr_n || !host_in.rd_n
        || trail_w || (host_in.rd_n && !rd_prev);
    assign st_rd = !host_in.cs_n && !host_in.rd_n && host_in.register_select;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_prev <= 1'b1;
            rd_prev <= 1'b1;
            wr_hist <= 4'h0;
            act_hist <= 4'h0;
        end else begin
            wr_prev <= host_in.wr_n;
            rd_prev <= host_in.rd_n;
            wr_hist <= {wr_hist[2:0], trail_w};
            act_hist <= {act_hist[2:0], act};
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_oe_drive_sel: assert property (!host_in.cs_n && !host_in.rd_n
        |-> !host_dout_oe_n) else $error("bus not driven on read");
    a_oe_release_idle: assert property (host_in.rd_n
        || (host_in.cs_n && acknowledge_pin_n) |-> host_dout_oe_n)
        else $error("bus driven without read");
    a_reset_state: assert property (disable iff (1'b0) rst
        |-> port_pins == SPHG_PORT_RST && host_dout == 8'h00
        && fw_rdata == '0) else $error("reset values wrong");
    a_req_ack_drop: assert property (host_in.wr_n
        && $past(!acknowledge_pin_n && !host_in.wr_n)
        |-> ##[1:3] !port_pins[6]) else $error("request not withdrawn");
    a_status_lock: assert property (st_rd[*3] |-> $stable(host_dout))
        else $error("status changed during host read");
    a_pins_quiet: assert property ($changed(port_pins)
        |-> (|act_hist) || act) else $error("pins changed unprompted");
    a_flag_trail: assert property ($fell(port_pins[5])
        |-> $past(fw_req.wr) || ((|wr_hist) && $past(host_in.wr_n)))
        else $error("input flag moved before trailing edge");
    a_fw_hold: assert property (!$past(fw_req.rd)
        |-> $stable(fw_rdata)) else $error("firmware read data moved");
    cover property ($rose(port_pins[1]));
    cover property ($rose(port_pins[6]));
    cover property (st_rd[*3]);
endmodule

bind sphg_host_port sphg_host_port_sva i_sphg_host_port_sva (
    .mclk(mclk),
    .rst(rst),
    .host_in(host_in),
    .host_dout(host_dout),
    .host_dout_oe_n(host_dout_oe_n),
    .acknowledge_pin_n(acknowledge_pin_n),
    .port_pins(port_pins),
    .fw_req(fw_req),
    .fw_rdata(fw_rdata)
);

// >>> test/sphg_host_model.sv
// Behavioural host processor and transfer controller on the host bus.
`timescale 1ns/1ns
module sphg_host_model
    import sphg_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Host bus
    output sphg_host_in_t host_in,
    output logic acknowledge_pin_n,
    input wire logic [7:0] host_dout
);
    // ******************************************************************
    // Bus cycles
    // ******************************************************************
    initial begin
        host_in = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
        acknowledge_pin_n = 1'b1;
    end
    // Select picks command or data; ack selects.
    task automatic hw(input logic rs, input logic [7:0] d, input logic dma);
        @(posedge mclk);
        host_in <= '{dma, 1'b1, 1'b0, rs, d};
        acknowledge_pin_n <= !dma;
        @(posedge mclk);
        // A released bus shows the inverse, not a stale copy.
        host_in <= '{1'b1, 1'b1, 1'b1, rs, ~d};
        acknowledge_pin_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask
    // Status or output buffer read, held long enough to land.
    task automatic hr(input logic rs, output logic [7:0] v);
        @(posedge mclk);
        host_in <= '{1'b0, 1'b0, 1'b1, rs, host_in.din};
        repeat (3) @(posedge mclk);
        v = host_dout;
        host_in <= '{1'b1, 1'b1, 1'b1, rs, host_in.din};
        repeat (3) @(posedge mclk);
    endtask
endmodule

// >>> test/tb_sphg_host_port.sv
// Self-checking bench for the slave host port.
`timescale 1ns/1ns
module tb_sphg_host_port
    import sphg_pkg::*;
;
    // ******************************************************************
    // Signals, tasks and scenarios
    // ******************************************************************
    logic mclk;
    logic rst;
    sphg_host_in_t host_in;
    logic [7:0] host_dout;
    logic host_dout_oe_n;
    logic acknowledge_pin_n;
    logic [7:0] port_pins;
    sphg_fw_req_t fw_req;
    logic [SPHG_FW_DW-1:0] fw_rdata;
    int err_total;
    int checks;
    logic [15:0] seq [11] = '{16'h1d11, 16'h0dd0, 16'h1ff0, 16'h1d10,
        16'h1d10, 16'h0df1, 16'h1ff1, 16'h1ff3, 16'h1d11, 16'h1123, 16'h0dd3};
    sphg_host_port i_sphg_host_port (.mclk(mclk), .rst(rst),
        .host_in(host_in), .host_dout(host_dout),
        .host_dout_oe_n(host_dout_oe_n),
        .acknowledge_pin_n(acknowledge_pin_n), .port_pins(port_pins),
        .fw_req(fw_req), .fw_rdata(fw_rdata));
    sphg_host_model i_sphg_host_model (.mclk(mclk), .host_in(host_in),
        .acknowledge_pin_n(acknowledge_pin_n), .host_dout(host_dout));
    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic fwr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        fw_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        fw_req.wr <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic frd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        fw_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
        fw_req.rd <= 1'b0;
        @(posedge mclk);
        v = fw_rdata[7:0];
    endtask
    task automatic cfw(input logic [2:0] a, input logic [7:0] e,
        input logic [7:0] m, input string n);
        logic [7:0] v;
        frd(a, v);
        chk(n, e, v & m);
    endtask
    task automatic chs(input logic rs, input logic [7:0] e, input string n);
        logic [7:0] v;
        i_sphg_host_model.hr(rs, v);
        chk(n, e, v);
    endtask
    task automatic t_buffers();
        chk("pins", SPHG_PORT_RST, port_pins);
        chs(1'b1, SPHG_STATUS_RST, "host status");
        i_sphg_host_model.hw(1'b0, 8'haa, 1'b0);
        cfw(SPHG_REG_STATUS, 8'h02, 8'hff, "status");
        cfw(SPHG_REG_DATA, 8'haa, 8'hff, "in buffer");
        fwr(SPHG_REG_DATA, 16'h0055);
        chs(1'b1, 8'h01, "host status");
        chs(1'b0, 8'h55, "out buffer");
        chs(1'b1, 8'h00, "host status");
        i_sphg_host_model.hw(1'b1, 8'h3c, 1'b0);
        cfw(SPHG_REG_STATUS, 8'h0a, 8'hff, "status");
        cfw(SPHG_REG_DATA, 8'h3c, 8'hff, "in buffer");
    endtask
    task automatic t_status_move();
        fwr(SPHG_REG_DATA, 16'h0033);
        fwr(SPHG_REG_INSTR, {8'h5a, SPHG_OP_STATUS_MOVE});
        cfw(SPHG_REG_STATUS, 8'h59, 8'hff, "status");
        chs(1'b1, 8'h59, "host status");
        chs(1'b0, 8'h33, "out buffer");
    endtask
    task automatic t_flags();
        fwr(SPHG_REG_PORT, 16'h00cf);
        chk("pins", 8'hcf, port_pins);
        fwr(SPHG_REG_INSTR, {8'h00, SPHG_OP_FLAGS_EN});
        fwr(SPHG_REG_PORT, 16'h00ff);
        chk("flag pins", 8'h20, port_pins & 8'h30);
        i_sphg_host_model.hw(1'b0, 8'h12, 1'b0);
        chk("flag pins", 8'h00, port_pins & 8'h30);
        fwr(SPHG_REG_DATA, 16'h0044);
        chk("flag pins", 8'h10, port_pins & 8'h30);
        fwr(SPHG_REG_PORT, 16'h00cf);
        chk("flag pins", 8'h00, port_pins & 8'h30);
        cfw(SPHG_REG_DATA, 8'h12, 8'hff, "in buffer");
        chs(1'b0, 8'h44, "out buffer");
        fwr(SPHG_REG_PORT, 16'h00ff);
    endtask
    task automatic t_dma();
        fwr(SPHG_REG_INSTR, {8'h00, SPHG_OP_DMA_EN});
        chk("request", 8'h00, port_pins & 8'h40);
        fwr(SPHG_REG_PORT, 16'h00ff);
        chk("request", 8'h40, port_pins & 8'h40);
        i_sphg_host_model.hw(1'b0, 8'h77, 1'b1);
        chk("request", 8'h00, port_pins & 8'h40);
        cfw(SPHG_REG_DATA, 8'h77, 8'hff, "in buffer");
        fwr(SPHG_REG_PORT, 16'h00ff);
        chk("request", 8'h40, port_pins & 8'h40);
        fwr(SPHG_REG_INSTR, {8'h00, SPHG_OP_DMA_EN});
        chk("request", 8'h00, port_pins & 8'h40);
    endtask
    task automatic t_gate();
        logic [7:0] v;
        fwr(SPHG_REG_INSTR, {8'h00, SPHG_OP_GATE_EN});
        for (int i = 0; i < 11; i++) begin
            i_sphg_host_model.hw(seq[i][12], seq[i][11:4], 1'b0);
            cfw(SPHG_REG_STATUS, {6'h00, seq[i][1], 1'b0}, 8'h02,
                "input full");
            chk("gate pin", {6'h00, seq[i][0], 1'b0},
                port_pins & 8'h02);
            if (seq[i][1]) begin
                frd(SPHG_REG_DATA, v);
            end
        end
        fwr(SPHG_REG_PORT, 16'h0000);
        chk("gate pin", 8'h02, port_pins & 8'h02);
        cfw(SPHG_REG_MODE, 8'h04, 8'h04, "gate mode");
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // A hang of the handshakes would otherwise never end the run.
    initial begin
        #20000;
        err_total++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        fw_req = '0;
        err_total = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_buffers();
        t_status_move();
        t_flags();
        t_dma();
        t_gate();
        report_and_stop();
    end
endmodule
